//--- rtl/dc_pkg.sv
// Shared constants and carriers for the dot correction loader and scaler.
// Assumes one core clock domain; the link clock is sampled as data.
package dc_pkg;
    localparam int HDR_W = 6;
    localparam logic [5:0] HDR_DC8 = 6'h33;
    localparam int LEN_W = 10;
    localparam int PKT_W = 48;
    localparam logic [5:0] PKT_CNT_W = 6'h30;
    localparam int PRE_HDR_HI = 47;
    localparam int PRE_ADR_HI = 41;
    localparam int PRE_HDR2_HI = 31;
    localparam int PRE_LEN_HI = 25;
    localparam int PRE_PAR_HI = 15;
    localparam int PRE_LEN2_HI = 9;
    localparam logic [7:0] DC8_RESET = 8'hFF;
    localparam logic [5:0] DC6_RESET = 6'h3F;
    localparam int GS16_W = 16;
    localparam int GS10_W = 10;
    localparam int IDLE_CYCLES = 172;
    localparam int LINK_PERIOD_NS = 200;
    localparam int CORE_PERIOD_NS = 25;
    localparam int IDLE_CORE = (IDLE_CYCLES * LINK_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic [7:0] c;
        logic [7:0] b;
        logic [7:0] a;
    } dc_word_t;

    typedef struct packed {
        logic [15:0] c;
        logic [15:0] b;
        logic [15:0] a;
    } gs_set_t;
endpackage : dc_pkg

//--- rtl/dc_loader.sv
// Dot correction loader, FIFO and gray scale scaler.
// Assumes link pins come from outside core_clk and are synchronised here.
// Link edges pass unseen while clk_en is low; hold it high during a packet.
// What this block does
// - 8-bit correction for 16-bit gray scale, 6-bit for 10-bit.
// - 16-bit mode correction defaults to 255.
// - 10-bit mode correction defaults to 63.
// - 16-bit on-time equals gray times (correction+1) over 256.
// - 10-bit on-time equals gray times (correction+1) over 64.
// - 16-bit product truncated to 16 bits drives the pulse generator.
// - 10-bit product truncated to 10 bits drives the pulse generator.
// - Per device three 16-bit words, order C, B, A.
// - A 48-bit preamble precedes correction words.
// - Header 110011 at 47:42 and copy at 31:26.
// - Chain length minus one at 25:16, copy at 9:0.
// - Parity nibble at 15:12 covers length, address, header.
// - Parity bit 3 is parity of the lower three bits.
// - Preamble bits 11:10 are ignored.
// - Values at 39:32, 23:16, 7:0 with copies above.
// - Latch a channel only when copy byte matches value.
`timescale 1ns/1ps
`default_nettype none

module dc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Count is one bit wider so full and empty differ
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : dc_fifo

module dc_loader #(
    parameter int CHAIN_POS = 0
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Link pins
    input wire logic link_clock_in,
    input wire logic serial_data_in,
    // Mode: high selects 16-bit gray scale
    input wire logic mode_16bit,
    // Gray scale input per channel
    input wire dc_pkg::gs_set_t gray_in,
    // Scaled outputs to pulse generator
    output dc_pkg::gs_set_t duty_out,
    // Status
    output logic packet_ok,
    output logic packet_bad,
    output logic drain_stall_n,
    output dc_pkg::dc_word_t corr_out
);
    import dc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE = 2'b01,
        ST_DATA = 2'b10,
        ST_SKIP = 2'b11
    } ld_state_t;

    logic ck_s1_q;
    logic ck_s2_q;
    logic ck_s3_q;
    logic sd_s1_q;
    logic sd_s2_q;
    logic rise;
    logic restart;
    logic last_word;

    logic [15:0] idle_q;
    logic armed;
    ld_state_t st_q;
    logic [PKT_W-1:0] sh_q;
    logic [PKT_W-1:0] sh_d;
    logic [5:0] bit_q;
    logic [LEN_W-1:0] dev_q;
    logic [LEN_W-1:0] target_q;
    logic pre_ok;
    logic hdr_ok;
    logic len_ok;
    logic par_ok;
    logic [3:0] par_calc;
    logic [2:0] par_low;
    logic word_done;

    logic fifo_ready;
    logic fvalid;
    logic fifo_out_valid;
    logic [3*16-1:0] fdata;
    dc_word_t corr_q;

    // Two flops before any logic reads the pins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            sd_s1_q <= 1'b0;
            sd_s2_q <= 1'b0;
        end else if (clk_en) begin
            ck_s1_q <= link_clock_in;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            sd_s1_q <= serial_data_in;
            sd_s2_q <= sd_s1_q;
        end
    end
    assign rise = ck_s2_q && !ck_s3_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            idle_q <= '0;
        end else if (clk_en) begin
            if (ck_s2_q || sd_s2_q) begin
                idle_q <= '0;
            end else if (idle_q != 16'(IDLE_CORE)) begin
                idle_q <= idle_q + 1'b1;
            end
        end
    end
    assign armed = (idle_q == 16'(IDLE_CORE));

    assign sh_d = {sh_q[PKT_W-2:0], sd_s2_q};
    assign word_done = rise && (bit_q == PKT_CNT_W - 6'h01);

    // parity recompute over the incoming preamble
    assign par_low[0] = ^sh_d[PRE_LEN_HI -: LEN_W];
    assign par_low[1] = ^sh_d[PRE_ADR_HI -: LEN_W];
    assign par_low[2] = ^sh_d[PRE_HDR_HI -: HDR_W];
    assign par_calc = {^par_low, par_low};

    // both header copies carry the correction code
    assign hdr_ok = (sh_d[PRE_HDR_HI -: HDR_W] == HDR_DC8) && (sh_d[PRE_HDR2_HI -: HDR_W] == HDR_DC8);
    // chain length and its copy agree
    assign len_ok = (sh_d[PRE_LEN_HI -: LEN_W] == sh_d[PRE_LEN2_HI -: LEN_W]);
    assign par_ok = (sh_d[PRE_PAR_HI -: 4] == par_calc);
    // any failure drops the packet; bits 11:10 unused
    assign pre_ok = hdr_ok && len_ok && par_ok;

    // Restart yields to a rising link edge so a first bit of 0 is not lost
    assign restart = armed && !rise;
    assign last_word = (dev_q == target_q);

    // Shift register, first bit ends on top
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sh_q <= '0;
        end else if (clk_en && rise) begin
            sh_q <= sh_d;
        end
    end

    // bit position in the current 48-bit word
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bit_q <= '0;
        end else if (clk_en) begin
            if (restart) begin
                bit_q <= '0;
            end else if (rise) begin
                bit_q <= word_done ? '0 : bit_q + 6'h01;
            end
        end
    end

    // frame state; bad preamble skips to the next gap
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= ST_IDLE;
        end else if (clk_en) begin
            if (restart) begin
                st_q <= ST_PRE;
            end else if (word_done) begin
                unique case (st_q)
                    ST_IDLE: begin
                        st_q <= ST_IDLE;
                    end
                    ST_PRE: begin
                        st_q <= pre_ok ? ST_DATA : ST_SKIP;
                    end
                    ST_DATA: begin
                        st_q <= last_word ? ST_SKIP : ST_DATA;
                    end
                    ST_SKIP: begin
                        st_q <= ST_SKIP;
                    end
                endcase
            end
        end
    end

    // word index within the data part
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dev_q <= '0;
        end else if (clk_en) begin
            if (restart) begin
                dev_q <= '0;
            end else if (word_done && st_q == ST_DATA) begin
                dev_q <= dev_q + 10'h001;
            end
        end
    end

    // nearest device takes the last word
    // A position beyond the chain never matches
    always_ff @(posedge core_clk) begin
        if (reset) begin
            target_q <= '0;
        end else if (clk_en && word_done && st_q == ST_PRE) begin
            target_q <= sh_d[PRE_LEN_HI -: LEN_W] - LEN_W'(CHAIN_POS);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            packet_ok <= 1'b0;
            packet_bad <= 1'b0;
        end else if (clk_en) begin
            packet_ok <= word_done && (st_q == ST_DATA) && last_word;
            packet_bad <= word_done && (st_q == ST_PRE) && !pre_ok;
        end
    end

    // Own word goes through FIFO; stall drops it rather than block the link
    assign fvalid = clk_en && word_done && (st_q == ST_DATA) && last_word;
    assign drain_stall_n = fifo_ready;

    dc_fifo #(.WIDTH(3*16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .in_valid(fvalid),
        .in_ready(fifo_ready),
        .in_data(sh_d),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fdata)
    );

    // per channel latch with copy check
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    corr_q[g*8 +: 8] <= DC8_RESET;
                end else if (clk_en && fifo_out_valid
                        && fdata[g*16+8 +: 8] == fdata[g*16 +: 8]) begin
                    corr_q[g*8 +: 8] <= fdata[g*16 +: 8];
                end
            end
        end
    endgenerate
    assign corr_out = corr_q;

    generate
        for (g = 0; g < 3; g++) begin : g_sc
            logic [8:0] f16;
            logic [6:0] f10;
            // Products keep every bit; the slice below truncates
            logic [24:0] p16;
            logic [16:0] p10;
            // 6-bit factor is top bits; default 255 gives 63
            assign f16 = {1'b0, corr_q[g*8 +: 8]} + 9'h001;
            assign f10 = {1'b0, corr_q[g*8+2 +: 6]} + 7'h01;
            assign p16 = gray_in[g*16 +: 16] * f16;
            assign p10 = gray_in[g*16 +: 10] * f10;
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    duty_out[g*16 +: 16] <= '0;
                end else if (clk_en) begin
                    duty_out[g*16 +: 16] <= mode_16bit ? p16[23:8] : {6'h00, p10[15:6]};
                end
            end
        end
    endgenerate
endmodule : dc_loader

`default_nettype wire

//--- tb/dc_loader_sva.sv
// Checker for the loader: scaling, defaults and verdict pulses.
// Sees only the top ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module dc_loader_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Watched signals
    input wire logic mode_16bit,
    input wire dc_pkg::gs_set_t gray_in,
    input wire dc_pkg::gs_set_t duty_out,
    input wire logic packet_ok,
    input wire logic packet_bad,
    input wire dc_pkg::dc_word_t corr_out
);
    import dc_pkg::*;
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    a_duty_a16: assert property (
        !$past(reset) && $past(clk_en) && $past(mode_16bit) |->
        duty_out.a == 16'((32'($past(gray_in.a)) * (32'($past(corr_out.a)) + 32'd1)) >> 8))
        else $error("duty a wrong");
    a_duty_c10: assert property (
        !$past(reset) && $past(clk_en) && !$past(mode_16bit) |->
        duty_out.c[9:0] == 10'((32'($past(gray_in.c[9:0])) * (32'($past(corr_out.c[7:2])) + 32'd1)) >> 6))
        else $error("duty c wrong");
    a_duty_b16: assert property (
        !$past(reset) && $past(clk_en) && $past(mode_16bit) |->
        duty_out.b == 16'((32'($past(gray_in.b)) * (32'($past(corr_out.b)) + 32'd1)) >> 8))
        else $error("duty b wrong in wide mode");
    a_duty_c16: assert property (
        !$past(reset) && $past(clk_en) && $past(mode_16bit) |->
        duty_out.c == 16'((32'($past(gray_in.c)) * (32'($past(corr_out.c)) + 32'd1)) >> 8))
        else $error("duty c wrong in wide mode");
    a_duty_a10: assert property (
        !$past(reset) && $past(clk_en) && !$past(mode_16bit) |->
        duty_out.a == 16'((32'($past(gray_in.a[9:0])) * (32'($past(corr_out.a[7:2])) + 32'd1)) >> 6))
        else $error("duty a wrong in narrow mode");
    a_duty_b10: assert property (
        !$past(reset) && $past(clk_en) && !$past(mode_16bit) |->
        duty_out.b == 16'((32'($past(gray_in.b[9:0])) * (32'($past(corr_out.b[7:2])) + 32'd1)) >> 6))
        else $error("duty b wrong in narrow mode");
    a_reset_corr: assert property ($fell(reset) |-> corr_out == {DC8_RESET, DC8_RESET, DC8_RESET})
        else $error("bad default");
    a_reset_duty: assert property ($fell(reset) |-> duty_out == 48'h0)
        else $error("duty not cleared");
    a_bad_keeps: assert property (packet_bad |=> $stable(corr_out) [*4])
        else $error("dropped packet loaded");
    a_ok_pulse: assert property (packet_ok |=> !packet_ok)
        else $error("ok not a pulse");
    a_bad_pulse: assert property (packet_bad |=> !packet_bad)
        else $error("bad not a pulse");
    a_ok_bad_excl: assert property (!(packet_ok && packet_bad))
        else $error("ok with bad");
endmodule : dc_loader_sva
bind dc_loader dc_loader_sva u_sva (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .mode_16bit(mode_16bit),
    .gray_in(gray_in), .duty_out(duty_out), .packet_ok(packet_ok), .packet_bad(packet_bad), .corr_out(corr_out));
`default_nettype wire

//--- tb/dc_link_ctrl.sv
// Chain controller model: frames queued words on the link.
// Assumes the bench fills q, then calls send.
`timescale 1ns/1ps
`default_nettype none
module dc_link_ctrl (
    // Link pins
    output logic link_clock_in,
    output logic serial_data_in
);
    logic [47:0] q[$];
    initial begin
        link_clock_in = 1'b0;
        serial_data_in = 1'b0;
    end
    task automatic send();
        #(180 * 200);
        foreach (q[i]) begin
            for (int b = 47; b >= 0; b--) begin
                serial_data_in = q[i][b];
                #100 link_clock_in = 1'b1;
                #100 link_clock_in = 1'b0;
            end
        end
        serial_data_in = 1'b0;
        q.delete();
    endtask : send
endmodule : dc_link_ctrl
`default_nettype wire

//--- tb/dc_loader_tb.sv
// Bench: correction packets over the link, random gray and mode.
// Assumes the link model; one note per packet verdict.
`timescale 1ns/1ps
`default_nettype none
module dc_loader_tb;
    import dc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic mode_16bit = 1'b1;
    logic clk_en = 1'b1;
    logic stall_n;
    gs_set_t frz;
    gs_set_t gray_in = '0;
    gs_set_t duty_out;
    dc_word_t corr_out;
    dc_word_t cur;
    logic packet_ok, packet_bad, got_bad;
    wire logic lclk, sdat;
    integer seed = 72133;
    int n_fail = 0;
    int total_checks = 0;
    logic [24:0] exp_q[$];
    logic [24:0] e;
    logic [47:0] bad_m[7] = '{48'h800000000000, 48'h000004000000, 48'h000000000001,
        48'h000000001000, 48'h000000002000, 48'h000000004000, 48'h000000008000};
    always #12.5 core_clk = ~core_clk;
    dc_link_ctrl ctrl (.link_clock_in(lclk), .serial_data_in(sdat));
    dc_loader #(.CHAIN_POS(0)) DUT (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .link_clock_in(lclk),
        .serial_data_in(sdat), .mode_16bit(mode_16bit), .gray_in(gray_in), .duty_out(duty_out),
        .packet_ok(packet_ok), .packet_bad(packet_bad), .drain_stall_n(stall_n), .corr_out(corr_out));
    task automatic chk(input logic [24:0] x, input logic [24:0] g);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic pkt(input logic [47:0] m, input logic [47:0] wm, input logic bad, input dc_word_t v);
        logic [9:0] len;
        logic [2:0] p;
        len = 10'h001;
        p = {^HDR_DC8, 1'b0, ^len};
        ctrl.q.push_back({HDR_DC8, 10'h000, HDR_DC8, len, ^p, p, 2'b00, len} ^ m);
        ctrl.q.push_back(48'($random(seed)));
        ctrl.q.push_back({v.c, v.c, v.b, v.b, v.a, v.a} ^ wm);
        if (wm[47:40] != 8'h00) v.c = cur.c;
        if (wm[31:24] != 8'h00) v.b = cur.b;
        if (wm[15:8] != 8'h00) v.a = cur.a;
        if (!bad) cur = v;
        exp_q.push_back({bad, cur});
        ctrl.send();
    endtask : pkt
    always @(posedge core_clk) begin
        gray_in <= gs_set_t'(48'({$random(seed), $random(seed)}));
        mode_16bit <= 1'($random(seed));
    end
    always @(posedge core_clk) begin
        if (!reset && (packet_ok === 1'b1 || packet_bad === 1'b1)) begin
            got_bad = packet_bad;
            repeat (4) @(posedge core_clk);
            e = exp_q.pop_front();
            chk(e, {got_bad, corr_out});
        end
    end
    initial begin
        cur = {DC8_RESET, DC8_RESET, DC8_RESET};
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        chk({1'b0, cur}, {1'b0, corr_out});
        clk_en <= 1'b0;
        repeat (2) @(posedge core_clk);
        frz = duty_out;
        repeat (8) @(posedge core_clk);
        chk(25'(frz), 25'(duty_out));
        chk(25'(48'(frz) >> 24), 25'(48'(duty_out) >> 24));
        clk_en <= 1'b1;
        pkt('0, '0, 1'b0, 24'h00017F);
        pkt('0, 48'h0000FF000000, 1'b0, 24'($random(seed)));
        pkt(48'h000000000C00, '0, 1'b0, 24'($random(seed)));
        foreach (bad_m[i]) pkt(bad_m[i], '0, 1'b1, 24'($random(seed)));
        pkt('0, 48'hFF0000000000, 1'b0, 24'h3FC0FF);
        repeat (20) @(posedge core_clk);
        chk(25'h0, 25'(exp_q.size()));
        chk(25'h1, 25'(stall_n));
        end_sim();
    end
    initial begin
        #1500000;
        n_fail++;
        end_sim();
    end
endmodule : dc_loader_tb
`default_nettype wire
